// file: verilog/gtis_top.sv
`default_nettype none
module gtis_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [gtis_pkg::GTIS_AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire gtis_pkg::gtis_evt_s evt,
  output logic [gtis_pkg::GTIS_TRIG_N-1:0] trig_output_unit_en,
  output logic summary_irq,
  output logic irq
);
  import gtis_pkg::*;

  function automatic logic [31:0] gtis_lanes(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : gtis_lanes

  logic wait_q;
  logic [31:0] rdata_q;
  logic [2:0] err_q;
  logic [2:0] done_q;
  logic [2:0] tirq_q;
  logic [1:0] sirq_q;
  logic [2:0] en_q;
  logic [2:0] notify_q;
  logic [1:0] sen_q;
  logic [2:0] mask_t_q;
  logic [1:0] mask_s_q;
  logic irq_q;
  logic summ_q;

  logic acc;
  logic [31:0] lm;
  logic [31:0] wd;
  logic wr_ed;
  logic wr_is;
  logic wr_ct;
  logic wr_mk;
  logic [2:0] en_lm;
  logic [2:0] en_clear;
  logic [2:0] fire_evt;
  logic [2:0] err_set;
  logic [2:0] done_set;
  logic [2:0] tirq_set;
  logic [1:0] sirq_set;
  logic [2:0] err_d;
  logic [2:0] done_d;
  logic [2:0] tirq_d;
  logic [1:0] sirq_d;
  logic [2:0] en_d;
  logic [2:0] mask_t_d;
  logic [1:0] mask_s_d;
  logic [31:0] rdata_d;

  // bus slave: one wait cycle, then the access completes
  assign acc = ce && !wait_q;
  assign lm = gtis_lanes(byteenable);
  assign wd = writedata & lm;
  assign wr_ed = acc && write && (address == GTIS_OFS_ERR_DONE);
  assign wr_is = acc && write && (address == GTIS_OFS_IRQ_STAT);
  assign wr_ct = acc && write && (address == GTIS_OFS_CTRL);
  assign wr_mk = acc && write && (address == GTIS_OFS_IRQ_MASK);

  // event qualification; only trigger and stamp sources feed
  assign fire_evt = evt.trig_fire & en_q;
  assign err_set = evt.trig_late & en_q & notify_q;
  assign done_set = fire_evt & notify_q;
  assign tirq_set = (err_set | done_set) & notify_q;
  assign sirq_set = evt.stamp_event & sen_q;

  assign en_lm = lm[GTIS_EN_LSB +: 3];
  assign en_clear = wr_ct ? (en_lm & ~wd[GTIS_EN_LSB +: 3]) : GTIS_TRIG_RST;

  always_comb begin
    err_d = err_q;
    if (wr_ed) begin
      err_d = err_d & ~wd[GTIS_ERR_LSB +: 3];
    end
    err_d = (err_d & ~en_clear) | err_set;
  end

  always_comb begin
    done_d = done_q;
    if (wr_ed) begin
      done_d = done_d & ~wd[GTIS_DONE_LSB +: 3];
    end
    done_d = done_d | done_set;
  end

  always_comb begin
    tirq_d = tirq_q;
    sirq_d = sirq_q;
    if (wr_is) begin
      tirq_d = tirq_d & ~wd[GTIS_TIRQ_LSB +: 3];
      sirq_d = sirq_d & ~wd[GTIS_SIRQ_LSB +: 2];
    end
    tirq_d = tirq_d | tirq_set;
    sirq_d = sirq_d | sirq_set;
  end

  always_comb begin
    en_d = en_q;
    if (wr_ct) begin
      en_d = (en_q & ~en_lm) | (wd[GTIS_EN_LSB +: 3] & en_lm);
    end
    en_d = en_d & ~fire_evt;
  end

  always_comb begin
    mask_t_d = mask_t_q;
    mask_s_d = mask_s_q;
    if (wr_mk) begin
      mask_t_d = (mask_t_q & ~lm[GTIS_TIRQ_LSB +: 3]) | wd[GTIS_TIRQ_LSB +: 3];
      mask_s_d = (mask_s_q & ~lm[GTIS_SIRQ_LSB +: 2]) | wd[GTIS_SIRQ_LSB +: 2];
    end
  end

  always_comb begin
    rdata_d = GTIS_WORD_RST;
    unique case (address)
      GTIS_OFS_ERR_DONE: begin
        rdata_d[GTIS_ERR_LSB +: 3] = err_q;
        rdata_d[GTIS_DONE_LSB +: 3] = done_q;
      end
      GTIS_OFS_IRQ_STAT: begin
        rdata_d[GTIS_TIRQ_LSB +: 3] = tirq_q;
        rdata_d[GTIS_SIRQ_LSB +: 2] = sirq_q;
      end
      GTIS_OFS_CTRL: begin
        rdata_d[GTIS_EN_LSB +: 3] = en_q;
        rdata_d[GTIS_NOTIFY_LSB +: 3] = notify_q;
        rdata_d[GTIS_SEN_LSB +: 2] = sen_q;
      end
      GTIS_OFS_IRQ_MASK: begin
        rdata_d[GTIS_TIRQ_LSB +: 3] = mask_t_q;
        rdata_d[GTIS_SIRQ_LSB +: 2] = mask_s_q;
      end
      default: begin
        rdata_d = GTIS_WORD_RST;
      end
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wait_q <= 1'b1;
      rdata_q <= GTIS_WORD_RST;
    end else if (ce) begin
      wait_q <= !((read || write) && wait_q);
      if ((read || write) && wait_q) begin
        rdata_q <= read ? rdata_d : GTIS_WORD_RST;
      end
    end
  end

  // trigger error and done flags
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      err_q <= GTIS_TRIG_RST;
      done_q <= GTIS_TRIG_RST;
    end else if (ce) begin
      err_q <= err_d;
      done_q <= done_d;
    end
  end

  // interrupt status bits
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tirq_q <= GTIS_TRIG_RST;
      sirq_q <= GTIS_STAMP_RST;
    end else if (ce) begin
      tirq_q <= tirq_d;
      sirq_q <= sirq_d;
    end
  end

  // control and mask
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      en_q <= GTIS_TRIG_RST;
      notify_q <= GTIS_TRIG_RST;
      sen_q <= GTIS_STAMP_RST;
      mask_t_q <= GTIS_TRIG_RST;
      mask_s_q <= GTIS_STAMP_RST;
    end else if (ce) begin
      en_q <= en_d;
      mask_t_q <= mask_t_d;
      mask_s_q <= mask_s_d;
      if (wr_ct) begin
        notify_q <= (notify_q & ~lm[GTIS_NOTIFY_LSB +: 3]) | wd[GTIS_NOTIFY_LSB +: 3];
        sen_q <= (sen_q & ~lm[GTIS_SEN_LSB +: 2]) | wd[GTIS_SEN_LSB +: 2];
      end
    end
  end

  // summary and masked interrupt line
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      summ_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      summ_q <= (|tirq_d) || (|sirq_d);
      irq_q <= (|(tirq_d & mask_t_d)) || (|(sirq_d & mask_s_d));
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign trig_output_unit_en = en_q;
  assign summary_irq = summ_q;
  assign irq = irq_q;

  property p_err_set;
    @(posedge clk_sys) disable iff (!resetn)
    (ce && |err_set) |=> ((err_q & $past(err_set)) == $past(err_set));
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set");

  property p_err_clr;
    @(posedge clk_sys) disable iff (!resetn)
    (ce && |(en_clear & ~err_set)) |=> ((err_q & $past(en_clear & ~err_set)) == 3'h0);
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error flag not cleared");

  property p_done_set;
    @(posedge clk_sys) disable iff (!resetn)
    (ce && |(evt.trig_fire & en_q & notify_q)) |=> ((done_q & $past(done_set)) == $past(done_set)) &&
      !(|(en_q & $past(evt.trig_fire & en_q)));
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_done_keep;
    @(posedge clk_sys) disable iff (!resetn)
    (ce && wr_ed) |=> ((done_q & $past(done_q & ~wd[GTIS_DONE_LSB +: 3])) ==
      $past(done_q & ~wd[GTIS_DONE_LSB +: 3]));
  endproperty
  a_done_keep: assert property (p_done_keep) else $error("done cleared by zero");

  property p_tirq_gate;
    @(posedge clk_sys) disable iff (!resetn)
    (ce && !wr_is) |=> ((tirq_q & ~$past(tirq_q)) == (tirq_q & ~$past(tirq_q) & $past(notify_q)));
  endproperty
  a_tirq_gate: assert property (p_tirq_gate) else $error("trigger irq without notify");

  property p_sirq_set;
    @(posedge clk_sys) disable iff (!resetn)
    (ce && |sirq_set) |=> ((sirq_q & $past(sirq_set)) == $past(sirq_set)) && summ_q;
  endproperty
  a_sirq_set: assert property (p_sirq_set) else $error("stamp irq not set");

  property p_summary;
    @(posedge clk_sys) disable iff (!resetn)
    summ_q == ((|tirq_q) || (|sirq_q));
  endproperty
  a_summary: assert property (p_summary) else $error("summary mismatch");

  property p_self_clear;
    @(posedge clk_sys) disable iff (!resetn)
    (ce && |fire_evt) |=> ((en_q & $past(fire_evt)) == 3'h0);
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("enable not self-cleared");

  property p_w1c;
    @(posedge clk_sys) disable iff (!resetn)
    (ce && wr_is && !(|tirq_set) && !(|sirq_set)) |=> ((tirq_q & $past(wd[GTIS_TIRQ_LSB +: 3])) == 3'h0) &&
      ((sirq_q & $past(wd[GTIS_SIRQ_LSB +: 2])) == 2'h0);
  endproperty
  a_w1c: assert property (p_w1c) else $error("irq bit not cleared");

  property p_bus_ack;
    @(posedge clk_sys) disable iff (!resetn)
    (ce && (read || write) && wait_q) |=> !wait_q ##1 (wait_q || !$past(ce));
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");

  c_err: cover property (@(posedge clk_sys) disable iff (!resetn) ce && |err_set);
  c_done: cover property (@(posedge clk_sys) disable iff (!resetn) ce && |done_set);
  c_stamp: cover property (@(posedge clk_sys) disable iff (!resetn) ce && |sirq_set);
  c_irq: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(irq_q));
endmodule : gtis_top
`default_nettype wire

// file: inc/gtis_pkg.sv
`default_nettype none
package gtis_pkg;
  localparam int GTIS_TRIG_N = 3;
  localparam int GTIS_STAMP_N = 2;
  localparam int GTIS_AW = 12;
  localparam logic [GTIS_AW-1:0] GTIS_OFS_ERR_DONE = 12'h524;
  localparam logic [GTIS_AW-1:0] GTIS_OFS_IRQ_STAT = 12'h528;
  localparam logic [GTIS_AW-1:0] GTIS_OFS_CTRL = 12'h5C0;
  localparam logic [GTIS_AW-1:0] GTIS_OFS_IRQ_MASK = 12'h5C4;
  localparam int GTIS_ERR_LSB = 16;
  localparam int GTIS_DONE_LSB = 0;
  localparam int GTIS_TIRQ_LSB = 16;
  localparam int GTIS_SIRQ_LSB = 0;
  localparam int GTIS_EN_LSB = 0;
  localparam int GTIS_NOTIFY_LSB = 4;
  localparam int GTIS_SEN_LSB = 8;
  localparam logic [2:0] GTIS_TRIG_RST = 3'h0;
  localparam logic [1:0] GTIS_STAMP_RST = 2'h0;
  localparam logic [31:0] GTIS_WORD_RST = 32'h0;
  typedef struct packed {
    logic [GTIS_TRIG_N-1:0] trig_fire;
    logic [GTIS_TRIG_N-1:0] trig_late;
    logic [GTIS_STAMP_N-1:0] stamp_event;
  } gtis_evt_s;
endpackage : gtis_pkg
`default_nettype wire

// file: tb/gtis_top_tb.sv
`default_nettype none
module gtis_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gtis_pkg::*;
  logic clk_sys;
  logic resetn;
  logic ce;
  logic [GTIS_AW-1:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  gtis_evt_s evt;
  logic [GTIS_TRIG_N-1:0] trig_output_unit_en;
  logic summary_irq;
  logic irq;
  int fail_count = 0;
  int compares = 0;

  gtis_top dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .evt(evt), .trig_output_unit_en(trig_output_unit_en),
    .summary_irq(summary_irq), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= ~is_wr;
    write <= is_wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      fail_count++;
      stop_test();
    end
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, exp, q);
  endtask : rd_chk

  // one-cycle event pulse, then settle past the capturing edge
  task automatic pulse(input logic [2:0] f, input logic [2:0] l, input logic [1:0] s);
    @(posedge clk_sys);
    evt <= gtis_evt_s'({f, l, s});
    @(posedge clk_sys);
    evt <= gtis_evt_s'(8'h00);
    @(negedge clk_sys);
  endtask : pulse

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    address = 12'h000;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h0;
    evt = gtis_evt_s'(8'h00);
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    chk("irq", 32'h0, 32'(irq));
    rd_chk("err_done", GTIS_OFS_ERR_DONE, 32'h0);
    rd_chk("irq_stat", GTIS_OFS_IRQ_STAT, 32'h0);
    // all enables, notify on units 0 and 1, stamp unit 0 enabled
    wr(GTIS_OFS_CTRL, 32'h0000_0137, 4'hF);
    wr(GTIS_OFS_IRQ_MASK, 32'h0001_0000, 4'hF);
    pulse(3'h4, 3'h0, 2'h0);
    chk("trig_en", 32'h3, 32'(trig_output_unit_en));
    chk("summary_irq", 32'h0, 32'(summary_irq));
    pulse(3'h2, 3'h0, 2'h0);
    chk("trig_en", 32'h1, 32'(trig_output_unit_en));
    chk("summary_irq", 32'h1, 32'(summary_irq));
    chk("irq", 32'h0, 32'(irq));
    pulse(3'h0, 3'h1, 2'h0);
    chk("irq", 32'h1, 32'(irq));
    rd_chk("err_done", GTIS_OFS_ERR_DONE, 32'h0001_0002);
    rd_chk("irq_stat", GTIS_OFS_IRQ_STAT, 32'h0003_0000);
    wr(GTIS_OFS_ERR_DONE, 32'h0, 4'hF);
    rd_chk("err_done", GTIS_OFS_ERR_DONE, 32'h0001_0002);
    wr(GTIS_OFS_ERR_DONE, 32'h2, 4'hE);
    rd_chk("err_done", GTIS_OFS_ERR_DONE, 32'h0001_0002);
    wr(GTIS_OFS_ERR_DONE, 32'h2, 4'hF);
    rd_chk("err_done", GTIS_OFS_ERR_DONE, 32'h0001_0000);
    wr(GTIS_OFS_CTRL, 32'h0000_0130, 4'hF);
    rd_chk("err_done", GTIS_OFS_ERR_DONE, 32'h0);
    rd_chk("ctrl", GTIS_OFS_CTRL, 32'h0000_0130);
    // late events with every enable low are ignored
    pulse(3'h0, 3'h7, 2'h0);
    rd_chk("err_done", GTIS_OFS_ERR_DONE, 32'h0);
    pulse(3'h0, 3'h0, 2'h3);
    rd_chk("irq_stat", GTIS_OFS_IRQ_STAT, 32'h0003_0001);
    wr(GTIS_OFS_IRQ_STAT, 32'h0001_0000, 4'hF);
    rd_chk("irq_stat", GTIS_OFS_IRQ_STAT, 32'h0002_0001);
    chk("irq", 32'h0, 32'(irq));
    wr(GTIS_OFS_IRQ_STAT, 32'h0002_0001, 4'hF);
    rd_chk("irq_stat", GTIS_OFS_IRQ_STAT, 32'h0);
    @(negedge clk_sys);
    chk("summary_irq", 32'h0, 32'(summary_irq));
    rd_chk("unmapped", 12'h100, 32'h0);
    // clock enable low freezes the stamp flag
    ce <= 1'b0;
    pulse(3'h0, 3'h0, 2'h1);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd_chk("irq_stat", GTIS_OFS_IRQ_STAT, 32'h0);
    // mid-run reset clears flags and control
    pulse(3'h0, 3'h0, 2'h1);
    chk("summary_irq", 32'h1, 32'(summary_irq));
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    chk("summary_irq", 32'h0, 32'(summary_irq));
    rd_chk("irq_stat", GTIS_OFS_IRQ_STAT, 32'h0);
    rd_chk("ctrl", GTIS_OFS_CTRL, 32'h0);
    stop_test();
  end
endmodule : gtis_top_tb
`default_nettype wire
